// [rtl/flash_prot.sv]
// Flash program/erase protection and verify-mode control with an APB register file.
// Assumes the vpp, standby and error inputs are asynchronous pins and are synchronised here.
//
// Functional notes
// - All control bits clear with Vpp selects prewrite-verify
// - Prewrite-verify applies verify level to addressed cells
// - Unselected blocks cannot be programmed or erased
// - Empty block selection protects all blocks
// - Software protection blocks program/erase mode entry
// - Overlay select protects all blocks, verify kept
// - Missing Vpp clears control and block selection
// - Reset or standby clears control and selection
// - Error sets flag, aborts, keeps registers
// - Error flag blocks program and erase entry
// - Verify modes still work under error protect
// - Only reset or hardware standby clears error
// - Registers writable in error state; soft standby clears
// - Error protect affects flash behaviour only
module flash_prot
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic vpp_present,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic op_error,
    input wire logic [3:0] target_block,
    output flash_prot_pkg::array_ctrl_s array_ctrl,
    output flash_prot_pkg::flash_mode_e flash_mode,
    output logic prewrite_ready
);
    import flash_prot_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    // Synchronised pin levels
    wire vpp_s = sync_b[0];
    wire hw_stby_s = sync_b[1];
    wire sw_stby_s = sync_b[2];
    wire err_s = sync_b[3];

    // Two stages; only the second stage is read by logic
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
        end
        else
        begin
            sync_a <= {op_error, sw_standby, hw_standby, vpp_present};
            sync_b <= sync_a;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] flash_mode_control_reg;
    logic [7:0] erase_block_select_hi;
    logic [7:0] erase_block_select_lo;
    logic [3:0] ram_control_reg;
    logic flash_error_flag;
    logic [8:0] prewrite_cnt;

    // APB decode
    wire access = psel && penable;
    wire wr_en = access && pwrite;
    wire hit_mode = paddr == MODE_CTRL_OFS;
    wire hit_block = paddr == BLOCK_SEL_OFS;
    wire hit_ram = paddr == RAM_CTRL_OFS;
    wire hit_stat = paddr == STATUS_OFS;
    wire mapped = hit_mode || hit_block || hit_ram || hit_stat;

    // Clearing conditions: Vpp loss, hardware standby, software standby
    wire ctrl_init = !vpp_s || hw_stby_s || sw_stby_s;
    wire ram_overlay_select = ram_control_reg[OVL_SEL_POS];

    // Views of the mode control bits
    wire p_bit = flash_mode_control_reg[P_POS];
    wire e_bit = flash_mode_control_reg[E_POS];
    wire program_verify_bit = flash_mode_control_reg[PROG_VERIFY_POS];
    wire erase_verify_bit = flash_mode_control_reg[ERASE_VERIFY_POS];

    // Block selection lookup; all zero naturally protects everything
    wire [15:0] block_sel = {erase_block_select_hi, erase_block_select_lo};
    wire block_ok = block_sel[target_block];

    // Common permission for program or erase; a clearing condition (Vpp loss, standby)
    // drops it at once so the array is not driven for the cycle the registers take to clear
    wire pe_allowed = !ctrl_init && !flash_error_flag && !ram_overlay_select && block_ok;

    // Byte-lane write enables; lanes with pstrb low keep their bytes
    wire wr_mode = wr_en && hit_mode && pstrb[0];
    wire wr_block_lo = wr_en && hit_block && pstrb[0];
    wire wr_block_hi = wr_en && hit_block && pstrb[1];
    wire wr_ram = wr_en && hit_ram && pstrb[0];

    // Control registers; writable even in error-protect state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flash_mode_control_reg <= MODE_CTRL_RST;
            erase_block_select_hi <= BLOCK_SEL_RST[15:8];
            erase_block_select_lo <= BLOCK_SEL_RST[7:0];
        end
        else if (ctrl_init)
        begin
            flash_mode_control_reg <= MODE_CTRL_RST;
            erase_block_select_hi <= BLOCK_SEL_RST[15:8];
            erase_block_select_lo <= BLOCK_SEL_RST[7:0];
        end
        else
        begin
            if (wr_mode)
                flash_mode_control_reg <= pwdata[7:0] & MODE_CTRL_WMASK;
            if (wr_block_lo)
                erase_block_select_lo <= pwdata[7:0];
            if (wr_block_hi)
                erase_block_select_hi <= pwdata[15:8];
        end
    end

    // Overlay bits clear only on reset or hardware standby
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ram_control_reg <= RAM_CTRL_RST;
        else if (hw_stby_s)
            ram_control_reg <= RAM_CTRL_RST;
        else if (wr_ram)
            ram_control_reg <= pwdata[3:0];
    end

    // Error flag: set while P or E set, no software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flash_error_flag <= 1'b0;
        else if (err_s && (p_bit || e_bit))
            flash_error_flag <= 1'b1;
        else if (hw_stby_s)
            flash_error_flag <= 1'b0;
    end

    // ----------------------------------------
    // Mode outputs
    // ----------------------------------------
    // Error takes effect the same cycle it is sampled, so abort is immediate
    wire err_now = flash_error_flag || (err_s && (p_bit || e_bit));
    wire prog_act = p_bit && pe_allowed && !err_now;
    wire erase_act = e_bit && !p_bit && pe_allowed && !err_now;
    wire pv_act = vpp_s && program_verify_bit;
    wire ev_act = vpp_s && erase_verify_bit && !program_verify_bit;
    wire pw_act = vpp_s && (flash_mode_control_reg[3:0] == 4'h0);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            array_ctrl <= '0;
            flash_mode <= MODE_IDLE;
        end
        else
        begin
            array_ctrl.program_en <= prog_act;
            array_ctrl.erase_en <= erase_act;
            array_ctrl.program_verify <= pv_act;
            array_ctrl.erase_verify <= ev_act;
            array_ctrl.prewrite_verify <= pw_act;
            if (prog_act)
                flash_mode <= MODE_PROGRAM;
            else if (erase_act)
                flash_mode <= MODE_ERASE;
            else if (pv_act || ev_act || pw_act)
                flash_mode <= MODE_VERIFY;
            else
                flash_mode <= MODE_IDLE;
        end
    end

    // Settling counter after prewrite-verify selection, informs software of the wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prewrite_cnt <= 9'h000;
        else if (!pw_act)
            prewrite_cnt <= 9'h000;
        else if (prewrite_cnt != 9'(PREWRITE_WAIT_CYC))
            prewrite_cnt <= prewrite_cnt + 9'h001;
    end
    assign prewrite_ready = prewrite_cnt == 9'(PREWRITE_WAIT_CYC);

    // ----------------------------------------
    // APB read path
    // ----------------------------------------
    wire [7:0] ram_rd = RAM_CTRL_FIXED | {flash_error_flag, 3'b000, ram_control_reg};
    // Status word: mode in bits 1:0, error flag in bit 8, settle flag in bit 9
    wire [31:0] stat_rd = {22'h000000, prewrite_ready, flash_error_flag, 6'h00, 2'(flash_mode)};
    // Register read select; unmapped offsets read as zero
    wire [31:0] rd_mux = hit_mode ? {24'h000000, flash_mode_control_reg} :
                         hit_block ? {16'h0000, block_sel} :
                         hit_ram ? {24'h000000, ram_rd} :
                         hit_stat ? stat_rd : 32'h00000000;

    // Zero wait states; unmapped addresses answer with pslverr
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // Read data captured in the setup cycle so it stands through the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
            prdata <= rd_mux;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_prog_needs_perm: assert property (@(posedge pclk) disable iff (!presetn)
        array_ctrl.program_en |-> $past(p_bit && vpp_s && !ram_overlay_select && block_ok))
        else $error("program active without permission");
    chk_overlay_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        ram_overlay_select |=> !array_ctrl.program_en && !array_ctrl.erase_en)
        else $error("overlay did not protect");
    chk_empty_sel: assert property (@(posedge pclk) disable iff (!presetn)
        (block_sel == 16'h0000) |=> !array_ctrl.program_en && !array_ctrl.erase_en)
        else $error("empty selection did not protect");
    chk_error_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        flash_error_flag && !hw_stby_s |=> flash_error_flag)
        else $error("error flag cleared without standby");
    chk_error_set: assert property (@(posedge pclk) disable iff (!presetn)
        err_s && (p_bit || e_bit) |=> flash_error_flag && !array_ctrl.program_en && !array_ctrl.erase_en)
        else $error("error not flagged or not aborted");
    chk_error_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        flash_error_flag |=> !array_ctrl.program_en && !array_ctrl.erase_en)
        else $error("program or erase under error");
    chk_verify_in_err: assert property (@(posedge pclk) disable iff (!presetn)
        flash_error_flag && vpp_s && program_verify_bit |=> array_ctrl.program_verify)
        else $error("verify lost in error state");
    chk_vpp_init: assert property (@(posedge pclk) disable iff (!presetn)
        !vpp_s |=> flash_mode_control_reg == MODE_CTRL_RST && block_sel == 16'h0000)
        else $error("registers not cleared without vpp");
    chk_standby_init: assert property (@(posedge pclk) disable iff (!presetn)
        sw_stby_s |=> flash_mode_control_reg == MODE_CTRL_RST && !array_ctrl.program_en)
        else $error("standby did not clear");
    chk_prewrite_sel: assert property (@(posedge pclk) disable iff (!presetn)
        vpp_s && flash_mode_control_reg[3:0] == 4'h0 |=> array_ctrl.prewrite_verify)
        else $error("prewrite verify not selected");
    chk_unsel_block: assert property (@(posedge pclk) disable iff (!presetn)
        !block_ok |=> !array_ctrl.program_en && !array_ctrl.erase_en)
        else $error("unselected block altered");

    // Standby, supply and flag ownership checks
    chk_standby_abort: assert property (@(posedge pclk) disable iff (!presetn)
        hw_stby_s || sw_stby_s |=> !array_ctrl.program_en && !array_ctrl.erase_en)
        else $error("program or erase kept in standby");
    chk_vpp_off_modes: assert property (@(posedge pclk) disable iff (!presetn)
        !vpp_s |=> array_ctrl == '0)
        else $error("array mode active without vpp");
    chk_erase_perm: assert property (@(posedge pclk) disable iff (!presetn)
        array_ctrl.erase_en |-> $past(e_bit && !p_bit && vpp_s && !ram_overlay_select && block_ok))
        else $error("erase active without permission");
    chk_p_wins: assert property (@(posedge pclk) disable iff (!presetn)
        p_bit && e_bit |=> !array_ctrl.erase_en)
        else $error("erase active while program bit set");
    chk_flag_readonly: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ram && !err_s && !hw_stby_s |=> flash_error_flag == $past(flash_error_flag))
        else $error("error flag changed by software write");
    chk_hw_stby_clear: assert property (@(posedge pclk) disable iff (!presetn)
        hw_stby_s && !(err_s && (p_bit || e_bit)) |=> !flash_error_flag)
        else $error("hardware standby did not clear error flag");
    chk_ready_in_pw: assert property (@(posedge pclk) disable iff (!presetn)
        prewrite_ready |-> array_ctrl.prewrite_verify)
        else $error("settle flag outside prewrite verify");

    // Scenario covers
    cov_program: cover property (@(posedge pclk) disable iff (!presetn) array_ctrl.program_en);
    cov_erase: cover property (@(posedge pclk) disable iff (!presetn) array_ctrl.erase_en);
    cov_error: cover property (@(posedge pclk) disable iff (!presetn) $rose(flash_error_flag));
    cov_prewrite: cover property (@(posedge pclk) disable iff (!presetn) $rose(prewrite_ready));
    cov_standby: cover property (@(posedge pclk) disable iff (!presetn) sw_stby_s && p_bit);

endmodule

// [rtl/flash_prot_pkg.sv]
// Package for the flash program/erase protection block.
// Assumes an APB slave on pclk at 100 MHz with 32-bit data.
package flash_prot_pkg;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] MODE_CTRL_OFS = 8'h00;
    localparam logic [7:0] BLOCK_SEL_OFS = 8'h04;
    localparam logic [7:0] RAM_CTRL_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;

    // ----------------------------------------
    // Mode control fields
    // ----------------------------------------
    localparam int VPP_EN_POS = 7;
    localparam int ERASE_VERIFY_POS = 3;
    localparam int PROG_VERIFY_POS = 2;
    localparam int E_POS = 1;
    localparam int P_POS = 0;
    localparam logic [7:0] MODE_CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_CTRL_WMASK = 8'h8F;
    localparam logic [15:0] BLOCK_SEL_RST = 16'h0000;

    // ----------------------------------------
    // RAM control fields
    // ----------------------------------------
    localparam int ERR_FLAG_POS = 7;
    localparam int OVL_SEL_POS = 3;
    localparam logic [7:0] RAM_CTRL_FIXED = 8'h70;
    localparam logic [3:0] RAM_CTRL_RST = 4'h0;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int PREWRITE_WAIT_US = 4;
    localparam int PREWRITE_WAIT_CYC = PREWRITE_WAIT_US * CLK_MHZ;
    localparam int RESET_HOLD_CYC = 10;
    localparam int NUM_BLOCKS = 16;

    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_PROGRAM,
        MODE_ERASE,
        MODE_VERIFY
    } flash_mode_e;

    // Mode strobes toward the flash array
    typedef struct packed {
        logic program_en;
        logic erase_en;
        logic program_verify;
        logic erase_verify;
        logic prewrite_verify;
    } array_ctrl_s;

endpackage

// [sim/flash_prot_test.sv]
// Self-checking bench for the flash program/erase protection block.
// Assumes flash_prot_pkg is compiled first; the bench alone drives every port.
module flash_prot_test;
    import flash_prot_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Stimulus signals and counters
    // ----------------------------------------
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, vpp_present = 0, hw_standby = 0, sw_standby = 0, op_error = 0, prewrite_ready;
    logic [3:0] target_block = 4'h0;
    array_ctrl_s array_ctrl;
    flash_mode_e flash_mode;
    int err_total = 0, checks = 0, cycles = 0;

    flash_prot u_flash_prot (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .vpp_present(vpp_present), .hw_standby(hw_standby), .sw_standby(sw_standby), .op_error(op_error),
        .target_block(target_block), .array_ctrl(array_ctrl), .flash_mode(flash_mode),
        .prewrite_ready(prewrite_ready));

    // Clock and hang guard; the ceiling is far above the fewer than a thousand cycles used
    initial
    begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total = err_total + 1;
            finish_test();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask

    // Lets the two-flop input synchronisers and the registered outputs catch up
    task automatic settle();
        repeat (4) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic mode_is(input logic [4:0] ac);
        settle();
        chk({27'h0, array_ctrl}, {27'h0, ac});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic block_protect();
        wr(MODE_CTRL_OFS, 32'h01);
        mode_is(5'b00000);
        wr(BLOCK_SEL_OFS, 32'h0001);
        mode_is(5'b10000);
        chk({30'h0, flash_mode}, 32'h1);
        rd(STATUS_OFS, 32'h00000001);
        @(posedge pclk) target_block <= 4'h1;
        mode_is(5'b00000);
        wr(BLOCK_SEL_OFS, 32'h8000);
        @(posedge pclk) target_block <= 4'hF;
        mode_is(5'b10000);
        wr(MODE_CTRL_OFS, 32'h00);
        mode_is(5'b00001);
        wr(MODE_CTRL_OFS, 32'h02);
        mode_is(5'b01000);
        chk({30'h0, flash_mode}, 32'h2);
    endtask

    task automatic overlay_protect();
        wr(RAM_CTRL_OFS, 32'h08);
        mode_is(5'b00000);
        wr(MODE_CTRL_OFS, 32'h06);
        mode_is(5'b00100);
        wr(RAM_CTRL_OFS, 32'h00);
    endtask

    task automatic error_protect();
        wr(MODE_CTRL_OFS, 32'h01);
        mode_is(5'b10000);
        @(posedge pclk) op_error <= 1;
        settle();
        @(posedge pclk) op_error <= 0;
        mode_is(5'b00000);
        rd(RAM_CTRL_OFS, 32'hF0);
        rd(STATUS_OFS, 32'h00000100);
        rd(MODE_CTRL_OFS, 32'h01);
        rd(BLOCK_SEL_OFS, 32'h8000);
        wr(RAM_CTRL_OFS, 32'h00);
        rd(RAM_CTRL_OFS, 32'hF0);
        wr(MODE_CTRL_OFS, 32'h05);
        mode_is(5'b00100);
        wr(MODE_CTRL_OFS, 32'h0A);
        mode_is(5'b00010);
        @(posedge pclk) sw_standby <= 1;
        settle();
        @(posedge pclk) sw_standby <= 0;
        rd(MODE_CTRL_OFS, 32'h0);
        rd(BLOCK_SEL_OFS, 32'h0);
        rd(RAM_CTRL_OFS, 32'hF0);
        @(posedge pclk) hw_standby <= 1;
        settle();
        @(posedge pclk) hw_standby <= 0;
        settle();
        rd(RAM_CTRL_OFS, 32'h70);
    endtask

    task automatic vpp_and_reset();
        logic [31:0] r;
        logic e;
        apb(1'b1, 8'h10, 32'hFF, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 8'h10, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        @(posedge pclk) target_block <= 4'h0;
        wr(BLOCK_SEL_OFS, 32'h00FF);
        wr(MODE_CTRL_OFS, 32'h01);
        mode_is(5'b10000);
        @(posedge pclk) vpp_present <= 0;
        mode_is(5'b00000);
        @(posedge pclk) vpp_present <= 1;
        settle();
        rd(MODE_CTRL_OFS, 32'h0);
        rd(BLOCK_SEL_OFS, 32'h0);
        @(posedge pclk) target_block <= 4'h0;
        wr(BLOCK_SEL_OFS, 32'h0001);
        wr(MODE_CTRL_OFS, 32'h01);
        mode_is(5'b10000);
        @(posedge pclk) sw_standby <= 1;
        mode_is(5'b00001);
        @(posedge pclk) sw_standby <= 0;
        settle();
        wr(BLOCK_SEL_OFS, 32'h0001);
        wr(MODE_CTRL_OFS, 32'h01);
        mode_is(5'b10000);
        @(posedge pclk) presetn <= 0;
        repeat (RESET_HOLD_CYC) @(posedge pclk);
        presetn <= 1;
        mode_is(5'b00001);
        rd(BLOCK_SEL_OFS, 32'h0);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        @(negedge pclk);
        chk({27'h0, array_ctrl}, 32'h0);
        @(posedge pclk) vpp_present <= 1;
        mode_is(5'b00001);
        repeat (PREWRITE_WAIT_CYC + 10) @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, prewrite_ready}, 32'h1);
        rd(STATUS_OFS, 32'h00000203);
        block_protect();
        overlay_protect();
        error_protect();
        vpp_and_reset();
        finish_test();
    end
endmodule
